// file: afe_sample_clamp_timing.sv
// pixel sample, reference sample and clamp timing with byte-wide result output
`include "afe_timing_params.svh"
`timescale 1ns/1ps
// ==========================================================================
// Summary of operation
// [R1] one result leaves the output pins every two clock cycles
// [R2] controller keeps the master clock at or below 12 MHz; the bench clock has a 40 ns period, 25 MHz
// [R3] strobe high at an edge means the signal sample at the next edge
// [R4] reference sample follows the signal sample by one to four cycles
// [R5] without double sampling the internal reference is sampled instead
// [R6] pixel spacing follows the strobe spacing, only valid spacings accepted
// [R7] clamp and sample strobes together clamp all three inputs for next pixel
// [R8] clamp level is upper or lower reference by polarity bit 4
// [R9] every result is fourteen bits wide
// [R10] receiver may use only twelve of the fourteen bits
// [R11] result goes out as high byte d13..d6 then low byte d5..d0 with zeros
// [R12] clamp strobe without sample strobe is ignored
module afe_sample_clamp_timing (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // strobes from the scanner timing controller
  input  wire logic                      pixel_sample_strobe,
  input  wire logic                      clamp_strobe,
  // configuration, sample mode byte
  input  wire logic [7:0]                sample_mode,
  // raw conversion result from the converter core
  input  wire logic [`RESULT_WIDTH-1:0]  conversion_result,
  // analog switch controls
  output logic                           signal_sample_reg,
  output logic                           reference_sample_reg,
  output logic                           internal_ref_select_reg,
  output logic                           clamp_active_reg,
  output logic                           clamp_level_upper_reg,
  output logic                           spacing_error_reg,
  // byte-wide result output
  output logic [`BYTE_WIDTH-1:0]         output_byte_pins,
  output logic                           output_byte_high_reg,
  output logic                           output_byte_valid_reg
);
  // ========================================================================
  // configuration decode
  logic       double_sampling_enable;
  logic [1:0] reference_sample_delay;
  logic       polarity_upper;
  assign double_sampling_enable = sample_mode[`MODE_DOUBLE_SAMP_BIT];
  assign reference_sample_delay = sample_mode[`MODE_REF_DELAY_LSB +: 2];
  assign polarity_upper         = sample_mode[`MODE_POLARITY_BIT];
  // the mode byte is a plain level each cycle; changing the delay field while a
  // pixel is in flight affects only later pixels, since the delay
  // is latched when the signal sample is launched

  // ========================================================================
  // sample sequencer
  afe_timing_pkg::sample_state_t state_reg;
  logic [1:0]                    ref_count_reg;
  logic [`SPACING_WIDTH-1:0]     spacing_reg;
  logic                          seen_pixel_reg;
  logic                          clamp_pending_reg;
  logic                          take_pixel;

  // a strobe whose spacing is too short is dropped, the core cannot settle
  assign take_pixel = pixel_sample_strobe &&
                      (!seen_pixel_reg || spacing_reg >= `MIN_PIXEL_SPACING); // R6

  // cycle walk for one pixel, edge n is where the strobe is seen high:
  //   n     strobe taken, sequencer leaves idle
  //   n+1   signal sample pulse launched
  //   n+2+d reference sample pulse launched, d from the delay field
  //   n+3+d capture pulse launched, result written into the buffer at n+4+d
  // a new strobe is taken only in idle or on the reference edge itself,
  // so strobe spacing below the reference delay plus two loses pixels
  // state flow: strobe, signal sample next edge, then reference after delay
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg            <= afe_timing_pkg::ST_IDLE;
      ref_count_reg        <= 2'h0;
      signal_sample_reg    <= 1'b0;
      reference_sample_reg <= 1'b0;
    end else begin
      signal_sample_reg    <= 1'b0;
      reference_sample_reg <= 1'b0;
      case (state_reg)
        afe_timing_pkg::ST_IDLE: begin
          if (take_pixel) begin
            state_reg <= afe_timing_pkg::ST_SIGNAL;
          end
        end
        afe_timing_pkg::ST_SIGNAL: begin
          signal_sample_reg <= 1'b1; // R3
          ref_count_reg     <= reference_sample_delay;
          state_reg         <= afe_timing_pkg::ST_REF;
        end
        afe_timing_pkg::ST_REF: begin
          if (ref_count_reg == 2'h0) begin
            reference_sample_reg <= 1'b1; // R4
            state_reg <= take_pixel ? afe_timing_pkg::ST_SIGNAL : afe_timing_pkg::ST_IDLE;
          end else begin
            ref_count_reg <= ref_count_reg - 2'h1;
          end
        end
        default: begin
          state_reg <= afe_timing_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // spacing between strobes, saturating so long idle gaps stay legal
  // a dropped strobe freezes the spacing count for that cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      spacing_reg       <= '0;
      seen_pixel_reg    <= 1'b0;
      spacing_error_reg <= 1'b0;
    end else begin
      if (pixel_sample_strobe) begin
        spacing_error_reg <= !take_pixel; // R6
        if (take_pixel) begin
          spacing_reg    <= `SPACING_WIDTH'(1);
          seen_pixel_reg <= 1'b1;
        end
      end else if (spacing_reg != {`SPACING_WIDTH{1'b1}}) begin
        spacing_reg <= spacing_reg + 1'b1;
      end
    end
  end

  // ========================================================================
  // reference source and clamp
  // internal reference replaces the sensor reference when not double sampling
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      internal_ref_select_reg <= 1'b0;
      clamp_level_upper_reg   <= 1'b0;
    end else begin
      internal_ref_select_reg <= !double_sampling_enable; // R5
      clamp_level_upper_reg   <= polarity_upper; // R8
    end
  end

  // clamp is armed only when both strobes coincide, held for the next pixel
  // trade-off: clamp follows the next taken strobe rather than the
  // current one, so the switch changes inside a pixel only when strobe spacing is below the reference delay plus two
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clamp_pending_reg <= 1'b0;
      clamp_active_reg  <= 1'b0;
    end else if (take_pixel) begin
      clamp_pending_reg <= clamp_strobe; // R7 R12
      clamp_active_reg  <= clamp_pending_reg; // R7
    end
  end

  // ========================================================================
  // result buffer and byte output
  result_stream_if #(.WIDTH(`RESULT_WIDTH)) res_if ();
  logic                       fifo_valid;
  logic                       fifo_ready;
  logic [`RESULT_WIDTH-1:0]   fifo_data;
  logic                       capture_reg;
  afe_timing_pkg::byte_phase_t phase_reg;

  // limitation: a result arriving while the buffer is full is lost,
  // there is no overflow flag on the pins
  // result captured the cycle after the reference sample; dropped only if the buffer is full
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      capture_reg <= 1'b0;
    end else begin
      capture_reg <= reference_sample_reg && !capture_reg;
    end
  end
  assign res_if.valid = capture_reg;
  assign res_if.data  = conversion_result; // R9

  result_fifo #(
    .WIDTH      (`RESULT_WIDTH),
    .DEPTH      (`FIFO_DEPTH),
    .ADDR_WIDTH (`FIFO_ADDR_WIDTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_port   (res_if),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .out_data  (fifo_data)
  );

  // pop once per result, on the low byte, so two cycles per result
  assign fifo_ready = (phase_reg == afe_timing_pkg::BYTE_LOW); // R1

  // byte order per result:
  //   high byte carries bits 13 to 6 on all eight pins
  //   low byte carries bits 5 to 0 on the upper six pins
  //   the two lowest pins stay low on the low byte
  // the buffer absorbs bursts; at two cycles per result it keeps
  // pace with the tightest legal strobe spacing
  // high byte then low byte, low pins driven low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_reg             <= afe_timing_pkg::BYTE_HIGH;
      output_byte_pins      <= '0;
      output_byte_high_reg  <= 1'b0;
      output_byte_valid_reg <= 1'b0;
    end else begin
      output_byte_valid_reg <= fifo_valid;
      if (fifo_valid) begin
        if (phase_reg == afe_timing_pkg::BYTE_HIGH) begin
          output_byte_pins     <= fifo_data[`RESULT_WIDTH-1:`HIGH_BYTE_LSB]; // R11
          output_byte_high_reg <= 1'b1;
          phase_reg            <= afe_timing_pkg::BYTE_LOW;
        end else begin
          output_byte_pins     <= {fifo_data[`LOW_FIELD_WIDTH-1:0],
                                   {`LOW_PAD_WIDTH{1'b0}}}; // R11
          output_byte_high_reg <= 1'b0;
          phase_reg            <= afe_timing_pkg::BYTE_HIGH;
        end
      end
    end
  end
endmodule // afe_sample_clamp_timing

// file: afe_timing_params.svh
// timing constants, configuration field positions and output byte layout for the sample timing block
`ifndef AFE_TIMING_PARAMS_SVH
`define AFE_TIMING_PARAMS_SVH
`define CLK_PERIOD_NS        40
`define RESULT_WIDTH         14
`define BYTE_WIDTH           8
`define HIGH_BYTE_LSB        6
`define LOW_FIELD_WIDTH      6
`define LOW_PAD_WIDTH        2
`define REF_DELAY_MIN        1
`define SPACING_WIDTH        4
`define MIN_PIXEL_SPACING    4'h2
`define MAX_PIXEL_SPACING    4'h8
`define MODE_POLARITY_BIT    4
`define MODE_DOUBLE_SAMP_BIT 5
`define MODE_REF_DELAY_LSB   1
`define MODE_RESET_VALUE     8'h62
`define FIFO_DEPTH           16
`define FIFO_ADDR_WIDTH      4
`endif

// file: afe_timing_pkg.sv
// types used by the sample timing block for its sequencer states and output byte phase
package afe_timing_pkg;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SIGNAL = 2'b01,
    ST_REF    = 2'b10
  } sample_state_t;
  typedef enum logic {
    BYTE_HIGH = 1'b0,
    BYTE_LOW  = 1'b1
  } byte_phase_t;
endpackage

// file: afe_timing_props.sv
// concurrent checks on the ports of the sample timing block
`include "afe_timing_params.svh"
`timescale 1ns/1ps
// ==========
// checker
module afe_timing_props (
  // clock and reset
  input wire logic                     clk,
  input wire logic                     rst,
  // strobes and configuration
  input wire logic                     pixel_sample_strobe,
  input wire logic                     clamp_strobe,
  input wire logic [7:0]               sample_mode,
  input wire logic [`RESULT_WIDTH-1:0] conversion_result,
  // switch controls
  input wire logic                     signal_sample_reg,
  input wire logic                     reference_sample_reg,
  input wire logic                     internal_ref_select_reg,
  input wire logic                     clamp_active_reg,
  input wire logic                     clamp_level_upper_reg,
  input wire logic                     spacing_error_reg,
  // byte output
  input wire logic [`BYTE_WIDTH-1:0]   output_byte_pins,
  input wire logic                     output_byte_high_reg,
  input wire logic                     output_byte_valid_reg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [3:0] gap_reg;
  logic       pair_reg;
  logic       last_clamp_reg;
  // cycles since signal sample, saturating so a long idle never wraps
  always_ff @(posedge clk or posedge rst)
    if (rst) gap_reg <= 4'h0;
    else if (signal_sample_reg) gap_reg <= 4'h1;
    else if (gap_reg != 4'hF) gap_reg <= gap_reg + 4'h1;
  // clamp request of the strobe before the latest, the one that arms the clamp
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_clamp_reg <= 1'b0;
      pair_reg       <= 1'b0;
    end else if (pixel_sample_strobe) begin
      last_clamp_reg <= clamp_strobe;
      pair_reg       <= last_clamp_reg;
    end
  end
  sequence fresh_strobe;
    !pixel_sample_strobe ##1 pixel_sample_strobe;
  endsequence
  sequence high_byte;
    output_byte_valid_reg && output_byte_high_reg;
  endsequence
  chk_sample_next: assert property (fresh_strobe |-> ##[2:3] signal_sample_reg)
    else $error("signal sample missing after strobe");
  chk_ref_delay: assert property (reference_sample_reg |->
    gap_reg == {2'h0, sample_mode[2:1]} + 4'h1)
    else $error("reference sample delay wrong");
  chk_internal_ref: assert property ($stable(sample_mode)[*2] |->
    internal_ref_select_reg == !sample_mode[5])
    else $error("internal reference select wrong");
  chk_clamp_level: assert property ($stable(sample_mode)[*2] |->
    clamp_level_upper_reg == sample_mode[4])
    else $error("clamp level wrong");
  chk_spacing_drop: assert property (!pixel_sample_strobe ##1 pixel_sample_strobe[*2]
    |=> spacing_error_reg)
    else $error("close strobe not flagged");
  chk_spacing_ok: assert property (fresh_strobe |=> !spacing_error_reg)
    else $error("spaced strobe flagged");
  chk_byte_pair: assert property (high_byte |=>
    output_byte_valid_reg && !output_byte_high_reg)
    else $error("low byte does not follow high byte");
  chk_low_pad: assert property (output_byte_valid_reg && !output_byte_high_reg
    |-> output_byte_pins[1:0] == 2'h0)
    else $error("low byte padding not zero");
  chk_clamp_cause: assert property ($rose(clamp_active_reg) |-> pair_reg)
    else $error("clamp without strobe pair");
endmodule // afe_timing_props
bind afe_sample_clamp_timing afe_timing_props i_props (.*);

// file: result_fifo.sv
// parameterised first-in first-out buffer for conversion results
`timescale 1ns/1ps
module result_fifo #(
  parameter int WIDTH      = 14,
  parameter int DEPTH      = 16,
  parameter int ADDR_WIDTH = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // filling side
  result_stream_if.sink         in_port,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  logic [WIDTH-1:0]    mem_reg [DEPTH];
  logic [ADDR_WIDTH-1:0] wr_ptr_reg;
  logic [ADDR_WIDTH-1:0] rd_ptr_reg;
  logic [ADDR_WIDTH:0]   count_reg;
  logic                  push;
  logic                  pop;

  // honest full and empty from the word count
  assign in_port.ready = (count_reg != (ADDR_WIDTH+1)'(DEPTH));
  assign out_valid     = (count_reg != '0);
  assign out_data      = mem_reg[rd_ptr_reg];
  assign push          = in_port.valid && in_port.ready;
  assign pop           = out_valid && out_ready;

  // storage has no reset, the pointers guard it
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_port.data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // result_fifo

// file: result_stream_if.sv
// stream of conversion results between the timing logic and the result buffer
`timescale 1ns/1ps
interface result_stream_if #(parameter int WIDTH = 14);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

// file: scan_ctrl_model.sv
// scanner timing controller model driving the sampling strobes
`timescale 1ns/1ps
module scan_ctrl_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // commands from the bench
  input  wire logic       run,
  input  wire logic [3:0] gap,
  input  wire logic       clamp_req,
  // strobes to the block
  output logic            pixel_sample_strobe,
  output logic            clamp_strobe
);
  logic [3:0] cnt_reg;
  // a strobe every gap cycles; gap 1 holds it high, a fault on purpose
  always_ff @(posedge clk or posedge rst)
    if (rst) begin
      cnt_reg <= 4'h0;
      pixel_sample_strobe <= 1'b0;
    end else begin
      pixel_sample_strobe <= run && cnt_reg == 4'h0;
      if (run && cnt_reg == 4'h0) cnt_reg <= gap - 4'h1;
      else if (cnt_reg != 4'h0) cnt_reg <= cnt_reg - 4'h1;
    end
  // clamp is a level, so it can also stand without a strobe
  always_ff @(posedge clk or posedge rst)
    if (rst) clamp_strobe <= 1'b0;
    else clamp_strobe <= clamp_req;
endmodule // scan_ctrl_model

// file: tb.sv
// self-checking bench for the sample timing block
`timescale 1ns/1ps
// ==========
// bench
module tb;
  logic clk = 1'b0, rst = 1'b1, run = 1'b0, clamp_req = 1'b0;
  logic [3:0] gap = 4'h8;
  logic [7:0] sample_mode = 8'h62;
  logic [13:0] conversion_result = 14'h0;
  logic vs, cs, ss, rs, ir, ca, cu, se, bh, bv;
  logic [7:0] pins;
  int n_fail = 0, n_compared = 0, n;
  always #20 clk = ~clk;
  scan_ctrl_model i_ctrl (.clk(clk), .rst(rst), .run(run), .gap(gap),
    .clamp_req(clamp_req), .pixel_sample_strobe(vs), .clamp_strobe(cs));
  afe_sample_clamp_timing i_dut (.clk(clk), .rst(rst), .pixel_sample_strobe(vs),
    .clamp_strobe(cs), .sample_mode(sample_mode), .conversion_result(conversion_result),
    .signal_sample_reg(ss), .reference_sample_reg(rs), .internal_ref_select_reg(ir),
    .clamp_active_reg(ca), .clamp_level_upper_reg(cu), .spacing_error_reg(se),
    .output_byte_pins(pins), .output_byte_high_reg(bh), .output_byte_valid_reg(bv));
  task automatic wrap_up;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk_byte(input string what, input logic [7:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_flag(input string what, input logic exp, got);
    chk_byte(what, {7'h0, exp}, {7'h0, got});
  endtask
  // a wait that ran out ends the run at once
  task automatic give_up(input string what, input logic seen);
    chk_flag(what, 1'b1, seen);
    if (seen !== 1'b1) wrap_up();
  endtask
  task automatic pulse;
    @(posedge clk) run <= 1'b1;
    @(posedge clk) run <= 1'b0;
  endtask
  // every mode bit pair, levels follow the config byte
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk) sample_mode <= 8'(m << 4);
      repeat (3) @(negedge clk);
      chk_flag("internal ref", !m[1], ir);
      chk_flag("clamp upper", m[0], cu);
    end
    $display("t_modes done");
  endtask
  // each reference delay, with the result bytes of that pixel
  task automatic t_pixels;
    logic [13:0] res;
    for (int d = 0; d < 4; d++) begin
      res = 14'h2A5C + 14'(d);
      @(posedge clk) sample_mode <= 8'h20 | 8'(d << 1);
      conversion_result <= res;
      pulse();
      for (n = 0; n < 8 && ss !== 1'b1; n++) @(negedge clk);
      give_up("signal sample", ss);
      for (n = 0; n < 8 && rs !== 1'b1; n++) @(negedge clk);
      chk_byte("ref delay", 8'(d + 1), 8'(n));
      for (n = 0; n < 20 && !(bv === 1'b1 && bh === 1'b1); n++) @(negedge clk);
      give_up("high byte", bv && bh);
      chk_byte("high byte", res[13:6], pins);
      @(negedge clk);
      chk_flag("low phase", 1'b0, bh);
      chk_byte("low byte", {res[5:0], 2'h0}, pins);
      chk_byte("twelve bit low", {res[5:2], 4'h0}, {pins[7:4], 4'h0});
    end
    $display("t_pixels done");
  endtask
  // lone clamp ignored, paired clamp held for one pixel
  task automatic t_clamp;
    @(posedge clk) clamp_req <= 1'b1;
    repeat (6) @(negedge clk);
    @(posedge clk) clamp_req <= 1'b0;
    pulse();
    repeat (8) @(negedge clk);
    chk_flag("lone clamp", 1'b0, ca);
    @(posedge clk) clamp_req <= 1'b1;
    pulse();
    @(posedge clk) clamp_req <= 1'b0;
    repeat (8) @(negedge clk);
    chk_flag("clamp waits", 1'b0, ca);
    pulse();
    for (n = 0; n < 8 && ca !== 1'b1; n++) @(negedge clk);
    give_up("paired clamp", ca);
    repeat (8) @(negedge clk);
    pulse();
    repeat (8) @(negedge clk);
    chk_flag("clamp ends", 1'b0, ca);
    $display("t_clamp done");
  endtask
  // strobe held high is flagged, wider spacing clears it
  task automatic t_spacing;
    @(posedge clk) gap <= 4'h1;
    run <= 1'b1;
    for (n = 0; n < 8 && se !== 1'b1; n++) @(negedge clk);
    give_up("spacing error", se);
    @(posedge clk) gap <= 4'h5;
    repeat (12) @(negedge clk);
    chk_flag("spacing ok", 1'b0, se);
    @(posedge clk) run <= 1'b0;
    $display("t_spacing done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_modes();
    t_pixels();
    t_clamp();
    t_spacing();
    wrap_up();
  end
endmodule // tb
